// ---- rtl/kbh_pkg.sv ----
package kbh_pkg;
    localparam logic [31:0] ADDR_CMD = 32'hfff89000;
    localparam logic [31:0] ADDR_STS = 32'hfff89004;
    localparam logic [31:0] ADDR_SCAN = 32'hfff89008;
    localparam logic [31:0] ADDR_ASCII = 32'hfff8900c;
    localparam int CMD_EN_BIT = 8;
    localparam int CMD_TRAP_BIT = 9;
    localparam int STS_RX_BIT = 0;
    localparam int STS_TXC_BIT = 4;
    localparam int STS_TXE_BIT = 5;
    localparam int SCAN_EXT_BIT = 8;
    localparam int SCAN_REL_BIT = 9;
    localparam int SCAN_SHIFT_BIT = 10;
    localparam logic [7:0] CODE_EXTEND = 8'he0;
    localparam logic [7:0] CODE_RELEASE = 8'hf0;
    localparam logic [7:0] CODE_LSHIFT = 8'h12;
    localparam logic [7:0] CODE_RSHIFT = 8'h59;
    localparam logic [7:0] ASCII_NONE = 8'h2e;
    localparam int FRM_STOP = 10;
    localparam logic [3:0] CNT_PARITY = 4'h9;
    localparam logic [3:0] CNT_LAST = 4'ha;
    localparam logic [3:0] CNT_HOLD = 4'hb;
    localparam int CLK_MHZ = 40;
    localparam int INHIBIT_US = 60;
    localparam int INHIBIT_CYC = INHIBIT_US * CLK_MHZ + 1;
    localparam int TX_TIMEOUT_US = 15000;
    typedef enum logic [1:0] {TX_IDLE, TX_INHIBIT, TX_SEND, TX_RECOVER} kbh_tx_state_t;
endpackage : kbh_pkg

// ---- rtl/kbh_link_if.sv ----
`timescale 1ns/100ps
interface kbh_link_if;
    logic link_rst;
    logic link_clear;
    logic tx_mode;
    logic [7:0] tx_byte;
    logic tx_parity;
    logic done_tgl;
    logic [10:0] frame;
    logic drive_low;
    modport sys (output link_rst, link_clear, tx_mode, tx_byte, tx_parity,
                 input done_tgl, frame, drive_low);
    modport link (input link_rst, link_clear, tx_mode, tx_byte, tx_parity,
                  output done_tgl, frame, drive_low);
endinterface : kbh_link_if

// ---- rtl/kbh_link.sv ----
`timescale 1ns/100ps
module kbh_link (
    // Keyboard line levels.
    input wire logic kb_clk_in,
    input wire logic kb_dat_in,
    // System side.
    kbh_link_if.link lnk
);
    logic [3:0] cnt_reg, cnt_next, pos;
    logic [10:0] frame_reg, frame_next;
    logic tgl_reg, tgl_next, tx_bit;

    // Transmit words from the system side only change while the keyboard clock stands still.
    always_comb begin
        pos = (cnt_reg == kbh_pkg::CNT_HOLD) ? 4'h0 : cnt_reg;
        frame_next = {kb_dat_in, frame_reg[10:1]};
        tgl_next = tgl_reg;
        if (cnt_reg == kbh_pkg::CNT_HOLD && lnk.tx_mode) begin
            cnt_next = kbh_pkg::CNT_HOLD;
        end else if (pos == kbh_pkg::CNT_LAST) begin
            cnt_next = lnk.tx_mode ? kbh_pkg::CNT_HOLD : 4'h0;
            tgl_next = ~tgl_reg;
        end else begin
            cnt_next = pos + 4'h1;
        end
        if (cnt_reg == 4'h0) begin
            tx_bit = 1'b0;
        end else if (cnt_reg < kbh_pkg::CNT_PARITY) begin
            tx_bit = lnk.tx_byte[3'(cnt_reg - 4'h1)];
        end else begin
            tx_bit = lnk.tx_parity;
        end
    end

    always_ff @(negedge kb_clk_in or posedge lnk.link_rst or posedge lnk.link_clear) begin
        if (lnk.link_rst || lnk.link_clear) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(negedge kb_clk_in or posedge lnk.link_rst) begin
        if (lnk.link_rst) begin
            frame_reg <= 11'h000;
            tgl_reg <= 1'b0;
        end else begin
            frame_reg <= frame_next;
            tgl_reg <= tgl_next;
        end
    end

    // Data is released at the stop position so the acknowledge can be sampled.
    assign lnk.drive_low = lnk.tx_mode && cnt_reg <= kbh_pkg::CNT_PARITY && !tx_bit;
    assign lnk.done_tgl = tgl_reg;
    assign lnk.frame = frame_reg;

    property p_frame_count;
        @(negedge kb_clk_in) disable iff (lnk.link_rst || lnk.link_clear)
        (cnt_reg == kbh_pkg::CNT_LAST) |=> (tgl_reg != $past(tgl_reg));
    endproperty
    a_frame_count: assert property (p_frame_count) else $error("frame end not flagged");
endmodule : kbh_link

// ---- rtl/kbh_ascii.sv ----
`timescale 1ns/100ps
module kbh_ascii (
    // Scan code in.
    input wire logic [7:0] scan_in,
    input wire logic shift_in,
    // Translation out.
    output logic [7:0] ascii_out
);
    logic [7:0] base;

    always_comb begin
        case (scan_in)
            8'h1c: base = 8'h61;
            8'h32: base = 8'h62;
            8'h21: base = 8'h63;
            8'h23: base = 8'h64;
            8'h24: base = 8'h65;
            8'h2b: base = 8'h66;
            8'h34: base = 8'h67;
            8'h33: base = 8'h68;
            8'h43: base = 8'h69;
            8'h3b: base = 8'h6a;
            8'h42: base = 8'h6b;
            8'h4b: base = 8'h6c;
            8'h3a: base = 8'h6d;
            8'h31: base = 8'h6e;
            8'h44: base = 8'h6f;
            8'h4d: base = 8'h70;
            8'h15: base = 8'h71;
            8'h2d: base = 8'h72;
            8'h1b: base = 8'h73;
            8'h2c: base = 8'h74;
            8'h3c: base = 8'h75;
            8'h2a: base = 8'h76;
            8'h1d: base = 8'h77;
            8'h22: base = 8'h78;
            8'h35: base = 8'h79;
            8'h1a: base = 8'h7a;
            8'h45: base = 8'h30;
            8'h16: base = 8'h31;
            8'h1e: base = 8'h32;
            8'h26: base = 8'h33;
            8'h25: base = 8'h34;
            8'h2e: base = 8'h35;
            8'h36: base = 8'h36;
            8'h3d: base = 8'h37;
            8'h3e: base = 8'h38;
            8'h46: base = 8'h39;
            8'h29: base = 8'h20;
            8'h5a: base = 8'h0d;
            default: base = kbh_pkg::ASCII_NONE;
        endcase
        // Only letters take an upper case form; digits stay as they are.
        if (shift_in && base >= 8'h61) begin
            ascii_out = base - 8'h20;
        end else begin
            ascii_out = base;
        end
    end
endmodule : kbh_ascii

// ---- rtl/kbh_top.sv ----
`timescale 1ns/100ps
module kbh_top #(
    parameter int TX_TIMEOUT_CYC = kbh_pkg::TX_TIMEOUT_US * kbh_pkg::CLK_MHZ
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Keyboard clock line; also the link clock.
    input wire logic kb_clk_in,
    output logic kb_clk_out,
    output logic kb_clk_oe_out,
    // Keyboard data line.
    input wire logic kb_dat_in,
    output logic kb_dat_out,
    output logic kb_dat_oe_out,
    // Interrupt.
    output logic irq_out
);
    kbh_link_if lnk ();

    logic [7:0] cmd_byte_reg, cmd_byte_next;
    logic cmd_en_reg, cmd_en_next, trap_reg, trap_next;
    logic rx_irq_reg, rx_irq_next, tx_irq_reg, tx_irq_next, tx_err_reg, tx_err_next;
    logic [7:0] scan_reg, scan_next, ascii_reg, ascii_next, tx_byte_reg, tx_byte_next;
    logic ext_reg, ext_next, rel_reg, rel_next, shift_reg, shift_next;
    logic ext_pend_reg, ext_pend_next, rel_pend_reg, rel_pend_next;
    kbh_pkg::kbh_tx_state_t state_reg, state_next;
    logic [19:0] tmr_reg, tmr_next;
    logic clear_reg, clear_next, lrst_reg, tx_mode_reg, tx_mode_next;
    logic [2:0] tgl_sync_reg, tgl_sync_next;
    logic [31:0] prdata_reg, prdata_next;
    logic wr_cmd, wr_sts, done, accept, report, is_shift;
    logic [7:0] byte_in, ascii_lut;

    function automatic logic frame_ok(input logic [10:0] f);
        frame_ok = !f[0] && f[kbh_pkg::FRM_STOP] && (^f[9:1]);
    endfunction : frame_ok

    function automatic logic addr_hit(input logic [31:0] a);
        addr_hit = a == kbh_pkg::ADDR_CMD || a == kbh_pkg::ADDR_STS ||
                   a == kbh_pkg::ADDR_SCAN || a == kbh_pkg::ADDR_ASCII;
    endfunction : addr_hit

    kbh_link u_link (
        .kb_clk_in(kb_clk_in),
        .kb_dat_in(kb_dat_in),
        .lnk(lnk)
    );

    kbh_ascii u_ascii (
        .scan_in(byte_in),
        .shift_in(shift_reg),
        .ascii_out(ascii_lut)
    );

    assign lnk.link_rst = lrst_reg;
    assign lnk.link_clear = clear_reg;
    assign lnk.tx_mode = tx_mode_reg;
    assign lnk.tx_byte = tx_byte_reg;
    assign lnk.tx_parity = ~^tx_byte_reg;

    // Lines are only ever pulled low; release is left to the pull-ups.
    assign kb_clk_out = 1'b0;
    assign kb_dat_out = 1'b0;
    assign kb_clk_oe_out = state_reg == kbh_pkg::TX_INHIBIT;
    assign kb_dat_oe_out = lnk.drive_low;
    assign irq_out = rx_irq_reg || tx_irq_reg;

    // Frame completion crosses as a toggle; only the last two stages are compared.
    always_comb begin
        tgl_sync_next = {tgl_sync_reg[1:0], lnk.done_tgl};
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tgl_sync_reg <= 3'h0;
            lrst_reg <= 1'b1;
        end else begin
            tgl_sync_reg <= tgl_sync_next;
            lrst_reg <= 1'b0;
        end
    end

    assign done = tgl_sync_reg[2] ^ tgl_sync_reg[1];
    assign byte_in = lnk.frame[8:1];
    assign wr_cmd = psel_in && penable_in && pwrite_in && paddr_in == kbh_pkg::ADDR_CMD;
    assign wr_sts = psel_in && penable_in && pwrite_in && paddr_in == kbh_pkg::ADDR_STS;
    assign accept = done && state_reg != kbh_pkg::TX_SEND && frame_ok(lnk.frame);
    assign is_shift = byte_in == kbh_pkg::CODE_LSHIFT || byte_in == kbh_pkg::CODE_RSHIFT;
    assign report = accept && byte_in != kbh_pkg::CODE_EXTEND &&
                    byte_in != kbh_pkg::CODE_RELEASE && !(is_shift && trap_reg);

    always_comb begin
        cmd_byte_next = cmd_byte_reg;
        cmd_en_next = cmd_en_reg;
        trap_next = trap_reg;
        tx_err_next = tx_err_reg;
        scan_next = scan_reg;
        ascii_next = ascii_reg;
        tx_byte_next = tx_byte_reg;
        ext_next = ext_reg;
        rel_next = rel_reg;
        shift_next = shift_reg;
        ext_pend_next = ext_pend_reg;
        rel_pend_next = rel_pend_reg;
        state_next = state_reg;
        tmr_next = tmr_reg;
        clear_next = clear_reg;
        tx_mode_next = tx_mode_reg;
        tx_irq_next = tx_irq_reg;
        rx_irq_next = rx_irq_reg;
        if (wr_sts && pwdata_in[kbh_pkg::STS_RX_BIT]) begin
            rx_irq_next = 1'b0;
        end
        if (wr_sts && pwdata_in[kbh_pkg::STS_TXC_BIT]) begin
            tx_irq_next = 1'b0;
        end
        case (state_reg)
            kbh_pkg::TX_IDLE: begin
                if (cmd_en_reg) begin
                    state_next = kbh_pkg::TX_INHIBIT;
                    tmr_next = 20'h0;
                    tx_err_next = 1'b0;
                    tx_byte_next = cmd_byte_reg;
                    clear_next = 1'b1;
                end
            end
            kbh_pkg::TX_INHIBIT: begin
                tmr_next = tmr_reg + 20'h1;
                if (tmr_reg == 20'(kbh_pkg::INHIBIT_CYC - 1)) begin
                    state_next = kbh_pkg::TX_SEND;
                    tmr_next = 20'h0;
                    clear_next = 1'b0;
                    tx_mode_next = 1'b1;
                end
            end
            kbh_pkg::TX_SEND: begin
                tmr_next = tmr_reg + 20'h1;
                if (done) begin
                    state_next = kbh_pkg::TX_IDLE;
                    tx_mode_next = 1'b0;
                    tx_err_next = lnk.frame[kbh_pkg::FRM_STOP];
                    tx_irq_next = 1'b1;
                    cmd_en_next = 1'b0;
                end else if (tmr_reg == 20'(TX_TIMEOUT_CYC - 1)) begin
                    // A silent keyboard would otherwise hold the controller forever.
                    state_next = kbh_pkg::TX_RECOVER;
                    tx_mode_next = 1'b0;
                    tx_err_next = 1'b1;
                    tx_irq_next = 1'b1;
                    cmd_en_next = 1'b0;
                    clear_next = 1'b1;
                end
            end
            kbh_pkg::TX_RECOVER: begin
                state_next = kbh_pkg::TX_IDLE;
                clear_next = 1'b0;
            end
            default: begin
                state_next = kbh_pkg::TX_IDLE;
            end
        endcase
        if (wr_cmd) begin
            // Bytes written during a transfer wait for the next enable.
            cmd_byte_next = pwdata_in[7:0];
            trap_next = pwdata_in[kbh_pkg::CMD_TRAP_BIT];
            cmd_en_next = cmd_en_next || pwdata_in[kbh_pkg::CMD_EN_BIT];
        end
        if (accept) begin
            if (byte_in == kbh_pkg::CODE_EXTEND) begin
                ext_next = 1'b1;
                ext_pend_next = 1'b1;
            end else if (byte_in == kbh_pkg::CODE_RELEASE) begin
                rel_next = 1'b1;
                rel_pend_next = 1'b1;
            end else begin
                if (is_shift) begin
                    shift_next = !rel_pend_reg;
                end
                ext_pend_next = 1'b0;
                rel_pend_next = 1'b0;
            end
        end
        if (report) begin
            scan_next = byte_in;
            ascii_next = ascii_lut;
            ext_next = ext_pend_reg;
            rel_next = rel_pend_reg;
            rx_irq_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cmd_byte_reg <= 8'h00;
            cmd_en_reg <= 1'b0;
            trap_reg <= 1'b0;
            rx_irq_reg <= 1'b0;
            tx_irq_reg <= 1'b0;
            tx_err_reg <= 1'b0;
            scan_reg <= 8'h00;
            ascii_reg <= 8'h00;
            tx_byte_reg <= 8'h00;
            ext_reg <= 1'b0;
            rel_reg <= 1'b0;
            shift_reg <= 1'b0;
            ext_pend_reg <= 1'b0;
            rel_pend_reg <= 1'b0;
            state_reg <= kbh_pkg::TX_IDLE;
            tmr_reg <= 20'h0;
            clear_reg <= 1'b0;
            tx_mode_reg <= 1'b0;
        end else begin
            cmd_byte_reg <= cmd_byte_next;
            cmd_en_reg <= cmd_en_next;
            trap_reg <= trap_next;
            rx_irq_reg <= rx_irq_next;
            tx_irq_reg <= tx_irq_next;
            tx_err_reg <= tx_err_next;
            scan_reg <= scan_next;
            ascii_reg <= ascii_next;
            tx_byte_reg <= tx_byte_next;
            ext_reg <= ext_next;
            rel_reg <= rel_next;
            shift_reg <= shift_next;
            ext_pend_reg <= ext_pend_next;
            rel_pend_reg <= rel_pend_next;
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            clear_reg <= clear_next;
            tx_mode_reg <= tx_mode_next;
        end
    end

    // Read data is captured in the setup phase and held through the access phase.
    always_comb begin
        prdata_next = prdata_reg;
        if (psel_in && !penable_in && !pwrite_in) begin
            prdata_next = 32'h0;
            if (paddr_in == kbh_pkg::ADDR_CMD) begin
                prdata_next[7:0] = cmd_byte_reg;
                prdata_next[kbh_pkg::CMD_EN_BIT] = cmd_en_reg;
                prdata_next[kbh_pkg::CMD_TRAP_BIT] = trap_reg;
            end else if (paddr_in == kbh_pkg::ADDR_STS) begin
                prdata_next[kbh_pkg::STS_RX_BIT] = rx_irq_reg;
                prdata_next[kbh_pkg::STS_TXC_BIT] = tx_irq_reg;
                prdata_next[kbh_pkg::STS_TXE_BIT] = tx_err_reg;
            end else if (paddr_in == kbh_pkg::ADDR_SCAN) begin
                prdata_next[7:0] = scan_reg;
                prdata_next[kbh_pkg::SCAN_EXT_BIT] = ext_reg;
                prdata_next[kbh_pkg::SCAN_REL_BIT] = rel_reg;
                prdata_next[kbh_pkg::SCAN_SHIFT_BIT] = shift_reg;
            end else if (paddr_in == kbh_pkg::ADDR_ASCII) begin
                prdata_next[7:0] = ascii_reg;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_reg <= 32'h0;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_hit(paddr_in);

    logic [11:0] inh_len_reg;
    always_ff @(posedge clk_in) begin
        if (rst_in || !kb_clk_oe_out) begin
            inh_len_reg <= 12'h0;
        end else begin
            inh_len_reg <= inh_len_reg + 12'h1;
        end
    end

    property p_inhibit_len;
        @(posedge clk_in) disable iff (rst_in)
        $fell(kb_clk_oe_out) |-> $past(inh_len_reg) >= 12'(kbh_pkg::INHIBIT_CYC - 1);
    endproperty
    a_inhibit_len: assert property (p_inhibit_len) else $error("inhibit too short");

    property p_start_low;
        @(posedge clk_in) disable iff (rst_in)
        $fell(kb_clk_oe_out) |-> kb_dat_oe_out && tx_mode_reg;
    endproperty
    a_start_low: assert property (p_start_low) else $error("data not low at release");

    property p_en_clear;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == kbh_pkg::TX_SEND && done && !wr_cmd) |=> !cmd_en_reg;
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("enable not cleared");

    property p_txc_set;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == kbh_pkg::TX_SEND && done) |=> tx_irq_reg && irq_out;
    endproperty
    a_txc_set: assert property (p_txc_set) else $error("completion flag missing");

    property p_txc_hold;
        @(posedge clk_in) disable iff (rst_in)
        tx_irq_reg && !(wr_sts && pwdata_in[kbh_pkg::STS_TXC_BIT]) |=> tx_irq_reg;
    endproperty
    a_txc_hold: assert property (p_txc_hold) else $error("completion flag lost");

    property p_err_start;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == kbh_pkg::TX_IDLE && cmd_en_reg) |=> !tx_err_reg [*2];
    endproperty
    a_err_start: assert property (p_err_start) else $error("error not cleared");

    property p_rx_report;
        @(posedge clk_in) disable iff (rst_in)
        report |=> rx_irq_reg && scan_reg == $past(byte_in);
    endproperty
    a_rx_report: assert property (p_rx_report) else $error("byte not reported");

    property p_prefix_quiet;
        @(posedge clk_in) disable iff (rst_in)
        accept && (byte_in == kbh_pkg::CODE_EXTEND || byte_in == kbh_pkg::CODE_RELEASE)
        |=> $stable(scan_reg) && $stable(ascii_reg);
    endproperty
    a_prefix_quiet: assert property (p_prefix_quiet) else $error("prefix reported");

    property p_release_ind;
        @(posedge clk_in) disable iff (rst_in)
        accept && byte_in == kbh_pkg::CODE_RELEASE |=> rel_reg && rel_pend_reg;
    endproperty
    a_release_ind: assert property (p_release_ind) else $error("release flag missing");

    property p_extend_ind;
        @(posedge clk_in) disable iff (rst_in)
        accept && byte_in == kbh_pkg::CODE_EXTEND |=> ext_reg && ext_pend_reg;
    endproperty
    a_extend_ind: assert property (p_extend_ind) else $error("extend flag missing");

    property p_trap;
        @(posedge clk_in) disable iff (rst_in)
        accept && is_shift && trap_reg |=> $stable(scan_reg);
    endproperty
    a_trap: assert property (p_trap) else $error("trapped shift reported");

    property p_shift_rel;
        @(posedge clk_in) disable iff (rst_in)
        accept && is_shift && rel_pend_reg |=> !shift_reg;
    endproperty
    a_shift_rel: assert property (p_shift_rel) else $error("shift not cleared");
endmodule : kbh_top

// ---- sim/kbh_kbd_model.sv ----
`timescale 1ns/100ps
module kbh_kbd_model (
    // Resolved lines.
    input wire logic clk_line_in,
    input wire logic dat_line_in,
    // Pull-down enables.
    output logic clk_oe_out,
    output logic dat_oe_out
);
    initial begin
        clk_oe_out = 1'b0;
        dat_oe_out = 1'b0;
    end
    task automatic tick();
        #6 clk_oe_out = 1'b1;
        #6 clk_oe_out = 1'b0;
    endtask : tick
    task automatic send(input logic [7:0] b, input logic bad);
        logic [10:0] f;
        f = {1'b1, ~^b ^ bad, b, 1'b0};
        wait (clk_line_in && dat_line_in);
        for (int i = 0; i < 11; i++) begin
            dat_oe_out = ~f[i];
            tick();
        end
        dat_oe_out = 1'b0;
    endtask : send
    // Host bits are read on rising edges, once the host has settled them.
    task automatic take(input logic ack, output logic [9:0] got);
        wait (!clk_line_in);
        wait (clk_line_in && !dat_line_in);
        #100;
        for (int i = 0; i < 11; i++) begin
            dat_oe_out = ack && i == 10;
            tick();
            if (i < 10) got[i] = dat_line_in;
        end
        dat_oe_out = 1'b0;
    endtask : take
endmodule : kbh_kbd_model

// ---- sim/kbh_top_tb.sv ----
`timescale 1ns/100ps
module kbh_top_tb;
    localparam logic [31:0] A_CMD = kbh_pkg::ADDR_CMD;
    localparam logic [31:0] A_STS = kbh_pkg::ADDR_STS;
    localparam logic [31:0] A_SCN = kbh_pkg::ADDR_SCAN;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, kc_oe, kd_oe, irq, m_c, m_d, err, kc_o, kd_o;
    logic [9:0] got;
    int failures = 0;
    int checks_done = 0;
    int n;
    wire clk_line = !(kc_oe | m_c);
    wire dat_line = !(kd_oe | m_d);
    always #12.5 clk_in = ~clk_in;
    kbh_top #(.TX_TIMEOUT_CYC(3000)) kbh_top_i (.clk_in(clk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .kb_clk_in(clk_line), .kb_clk_out(kc_o),
        .kb_clk_oe_out(kc_oe), .kb_dat_in(dat_line), .kb_dat_out(kd_o),
        .kb_dat_oe_out(kd_oe), .irq_out(irq));
    kbh_kbd_model kbd_i (.clk_line_in(clk_line), .dat_line_in(dat_line),
        .clk_oe_out(m_c), .dat_oe_out(m_d));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        #1 psel = 1'b1;
        pwr = w;
        paddr = a;
        pwdata = d;
        @(posedge clk_in);
        #1 pen = 1'b1;
        #1 err = pslverr;
        @(posedge clk_in);
        q = prdata;
        chk("pready", 32'h1, {31'h0, pready});
        #1 psel = 1'b0;
        pen = 1'b0;
    endtask : apb
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
        apb(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask : rd
    task automatic kk(input logic [7:0] b, input logic bad);
        kbd_i.send(b, bad);
        repeat (8) @(posedge clk_in);
    endtask : kk
    task automatic tx(input logic [7:0] b, input logic ack, input logic [31:0] sts);
        fork
            kbd_i.take(ack, got);
            begin
                apb(1'b1, A_CMD, {23'h0, 1'b1, b});
                n = 0;
                repeat (2600) begin
                    @(posedge clk_in);
                    #1 n += int'(kc_oe);
                end
            end
        join
        chk("inhibit", 32'd2401, 32'(n));
        chk("bits", {22'h0, 1'b1, ~^b, b}, {22'h0, got});
        rd(A_STS, sts, "status");
        rd(A_CMD, {24'h0, b}, "cmd");
    endtask : tx
    task automatic results();
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    initial begin
        #1_000_000;
        failures++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        #1 rst_in = 1'b0;
        for (int i = 0; i < 16; i += 4) rd(A_CMD + 32'(i), 32'h0, "reset");
        chk("line_out", 32'h0, {30'h0, kc_o, kd_o});
        apb(1'b1, 32'hfff89010, 32'h1ff);
        rd(32'hfff89010, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, err});
        kk(8'h01, 1'b0);
        rd(A_STS, 32'h1, "rx");
        rd(kbh_pkg::ADDR_ASCII, 32'h2e, "ascii");
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, A_STS, 32'h1);
        rd(A_STS, 32'h0, "rxclr");
        kk(8'he0, 1'b0);
        rd(A_STS, 32'h0, "ext");
        rd(A_SCN, 32'h101, "extbit");
        kk(8'hf0, 1'b0);
        kk(8'h01, 1'b0);
        rd(A_SCN, 32'h301, "relbit");
        apb(1'b1, A_STS, 32'h1);
        kk(8'h02, 1'b1);
        rd(A_STS, 32'h0, "parity");
        apb(1'b1, A_CMD, 32'h200);
        kk(8'h12, 1'b0);
        rd(A_STS, 32'h0, "trap");
        rd(A_SCN, 32'h701, "held");
        apb(1'b1, A_CMD, 32'h0);
        kk(8'h59, 1'b0);
        rd(A_SCN, 32'h459, "shift");
        kk(8'hf0, 1'b0);
        kk(8'h12, 1'b0);
        rd(A_SCN, 32'h212, "shiftrel");
        apb(1'b1, A_STS, 32'h1);
        tx(8'hed, 1'b1, 32'h10);
        chk("irq_tx", 32'h1, {31'h0, irq});
        apb(1'b1, A_STS, 32'h10);
        tx(8'hff, 1'b0, 32'h30);
        tx(8'h00, 1'b1, 32'h10);
        apb(1'b1, A_STS, 32'h10);
        // A keyboard that never clocks must still end the command with an error.
        apb(1'b1, A_CMD, 32'h1aa);
        repeat (5500) @(posedge clk_in);
        rd(A_STS, 32'h30, "timeout");
        rd(A_CMD, 32'haa, "abort_cmd");
        results();
    end
endmodule : kbh_top_tb
